// ---- hw/counter_core.sv ----
// eight-stage up/down count register with look-ahead terminal count
`timescale 1ns/100ps
module counter_core
   import counter_pkg::*;
#(
   parameter int W = CNT_W
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic async_clear_n,
   counter_core_if.core c
);
   logic [W-1:0] count_q;
   logic [W-1:0] count_d;
   wire at_end;
   wire do_count;

   // end state depends on direction
   assign at_end = c.up ? (&count_q) : (~|count_q);
   // look-ahead: decoded from state and chain enable, no ripple
   assign c.terminal_n = ~(~c.cet_n & at_end);
   assign do_count = ~c.cep_n & ~c.cet_n;
   assign c.count = count_q;

   always_comb begin
      count_d = count_q;
      if (c.step) begin
         if (!c.sclr_n) begin
            count_d = '0;
         end else if (!c.load_n && !c.cs_n) begin
            count_d = c.din;
         end else if (do_count) begin
            count_d = c.up ? count_q + 1'b1 : count_q - 1'b1;
         end
      end
   end

   // master clear overrides the clock entirely
   always_ff @(posedge aclk or negedge async_clear_n) begin
      if (!async_clear_n) begin
         count_q <= '0;
      end else if (!aresetn) begin
         count_q <= '0;
      end else begin
         count_q <= count_d;
      end
   end
endmodule

// ---- hw/counter_core_if.sv ----
// signals between the pin front end and the counting core
`timescale 1ns/100ps
interface counter_core_if #(parameter int W = 8);
   logic step;
   logic up;
   logic load_n;
   logic sclr_n;
   logic cep_n;
   logic cet_n;
   logic cs_n;
   logic [W-1:0] din;
   logic [W-1:0] count;
   logic terminal_n;

   modport core (
      input step,
      input up,
      input load_n,
      input sclr_n,
      input cep_n,
      input cet_n,
      input cs_n,
      input din,
      output count,
      output terminal_n
   );

   modport ctrl (
      output step,
      output up,
      output load_n,
      output sclr_n,
      output cep_n,
      output cet_n,
      output cs_n,
      output din,
      input count,
      input terminal_n
   );
endinterface

// ---- hw/counter_pkg.sv ----
// constants shared by the up/down counter block and its register slave
package counter_pkg;
   localparam int CNT_W = 8;
   localparam int AXI_AW = 8;
   localparam int AXI_DW = 32;

   // register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] MASK_OFS = 8'h08;
   localparam logic [7:0] COUNT_OFS = 8'h0c;

   // control fields
   localparam int CTRL_RUN_BIT = 0;
   localparam logic [7:0] CTRL_RST = 8'h01;

   // status and mask fields
   localparam int ST_W = 3;
   localparam int ST_TERM_BIT = 0;
   localparam int ST_LOAD_BIT = 1;
   localparam int ST_CLEAR_BIT = 2;
   localparam logic [2:0] STATUS_RST = 3'h0;
   localparam logic [2:0] MASK_RST = 3'h0;

   // count register fields above the count byte
   localparam int COUNT_TERM_BIT = 8;
   localparam int COUNT_DIR_BIT = 9;

   // response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // pin input vector layout, after synchronising
   localparam int PIN_W = 17;
   localparam int PIN_IO_LSB = 0;
   localparam int PIN_CLK = 8;
   localparam int PIN_DIR = 9;
   localparam int PIN_LOAD = 10;
   localparam int PIN_SCLR = 11;
   localparam int PIN_CEP = 12;
   localparam int PIN_CET = 13;
   localparam int PIN_CS = 14;
   localparam int PIN_OE = 15;
   localparam int PIN_ACLR = 16;
   // controls idle high, clock and data idle low
   localparam logic [16:0] PIN_RST = 17'h1fe00;
endpackage

// ---- hw/up_down_binary_counter_8bit.sv ----
// up/down counter with shared three-state port and register slave
//
// Behaviour
// - holds an eight-bit binary count that counts both up and down
// - every state change happens on a rising count clock edge, except master clear
// - direction input chooses increment or decrement on an enabled edge
// - parallel load presets the count from the i/o pins
// - master clear forces the count to zero at once, without a clock
// - synchronous clear zeroes the count at the next rising clock edge
// - parallel count enable, active low, must be asserted for counting
// - chain count enable gates counting and the terminal count output
// - active-low terminal count flags the end state in the current direction
// - terminal count is look-ahead decoded so counters cascade synchronously
// - the same eight pins carry load data in and count out
// - chip select qualifies loads and gates driving of the pins
// - output enable released puts the pins in high impedance
//
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module up_down_binary_counter_8bit
   import counter_pkg::*;
#(
   parameter int W = CNT_W
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [AXI_DW-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [AXI_DW-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic count_clock,
   input wire logic count_up,
   input wire logic parallel_load_n,
   input wire logic async_clear_n,
   input wire logic sync_clear_n,
   input wire logic count_enable_par_n,
   input wire logic count_enable_chain_n,
   input wire logic chip_select_n,
   input wire logic output_enable_n,
   input wire logic [W-1:0] io_in,
   output logic [W-1:0] io_out,
   output logic [W-1:0] io_oe,
   output logic terminal_count_n,
   output logic irq
);
   // pin synchroniser: stage one feeds stage two only
   logic [PIN_W-1:0] pin_raw;
   logic [PIN_W-1:0] s1_q;
   logic [PIN_W-1:0] s2_q;
   logic [PIN_W-1:0] s3_q;
   logic [PIN_W-1:0] filt_q;
   logic [PIN_W-1:0] filt_d;
   logic clk_prev_q;
   logic aclr_prev_q;
   logic term_prev_q;

   // registers
   logic [7:0] ctrl_q;
   logic [ST_W-1:0] status_q;
   logic [ST_W-1:0] status_d;
   logic [ST_W-1:0] mask_q;
   logic [ST_W-1:0] events;

   // bus slave state
   logic [AXI_AW-1:0] awaddr_q;
   logic aw_held_q;
   logic [AXI_DW-1:0] wdata_q;
   logic [3:0] wstrb_q;
   logic w_held_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [1:0] rresp_q;
   logic [AXI_DW-1:0] rdata_q;

   counter_core_if #(.W(W)) cif ();

   function automatic logic addr_known(input logic [AXI_AW-1:0] a);
      return (a == CTRL_OFS) || (a == STATUS_OFS) || (a == MASK_OFS) || (a == COUNT_OFS);
   endfunction

   assign pin_raw = {async_clear_n, output_enable_n, chip_select_n, count_enable_chain_n,
                     count_enable_par_n, sync_clear_n, parallel_load_n, count_up,
                     count_clock, io_in};

   // a bit moves only once stages two and three agree, which rejects one-cycle runts
   assign filt_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & filt_q);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_q <= PIN_RST;
         s2_q <= PIN_RST;
         s3_q <= PIN_RST;
         filt_q <= PIN_RST;
      end else begin
         s1_q <= pin_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         filt_q <= filt_d;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clk_prev_q <= 1'b0;
         aclr_prev_q <= 1'b1;
         term_prev_q <= 1'b1;
      end else begin
         clk_prev_q <= filt_q[PIN_CLK];
         aclr_prev_q <= filt_q[PIN_ACLR];
         term_prev_q <= cif.terminal_n;
      end
   end

   // rising edge of the pin clock, gated by the run bit
   wire clk_rise = filt_q[PIN_CLK] & ~clk_prev_q;
   wire step = clk_rise & ctrl_q[CTRL_RUN_BIT];

   assign cif.step = step;
   assign cif.up = filt_q[PIN_DIR];
   assign cif.load_n = filt_q[PIN_LOAD];
   assign cif.sclr_n = filt_q[PIN_SCLR];
   assign cif.cep_n = filt_q[PIN_CEP];
   assign cif.cet_n = filt_q[PIN_CET];
   assign cif.cs_n = filt_q[PIN_CS];
   assign cif.din = filt_q[PIN_IO_LSB +: W];

   // master clear bypasses the synchroniser so it acts without a clock;
   // its release is retimed so no count flop leaves reset close to an edge
   logic aclr_meta_n_q;
   logic core_clear_n_q;
   always_ff @(posedge aclk or negedge async_clear_n) begin
      if (!async_clear_n) begin
         aclr_meta_n_q <= 1'b0;
         core_clear_n_q <= 1'b0;
      end else begin
         aclr_meta_n_q <= 1'b1;
         core_clear_n_q <= aclr_meta_n_q;
      end
   end

   counter_core #(.W(W)) u_core (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_clear_n(core_clear_n_q),
      .c(cif.core)
   );

   // pin drive: shares pins with load data, so load releases them
   wire drive_pins = ~filt_q[PIN_CS] & ~filt_q[PIN_OE] & filt_q[PIN_LOAD];
   assign io_out = cif.count;
   assign io_oe = {W{drive_pins}};
   // decoded output: may glitch, not for clocking outside logic
   assign terminal_count_n = cif.terminal_n;

   // events: terminal reached, load taken, any clear
   wire load_evt = step & filt_q[PIN_SCLR] & ~filt_q[PIN_LOAD] & ~filt_q[PIN_CS];
   wire sclr_evt = step & ~filt_q[PIN_SCLR];
   wire aclr_evt = ~filt_q[PIN_ACLR] & aclr_prev_q;
   wire term_evt = ~cif.terminal_n & term_prev_q;

   always_comb begin
      events = '0;
      events[ST_TERM_BIT] = term_evt;
      events[ST_LOAD_BIT] = load_evt;
      events[ST_CLEAR_BIT] = sclr_evt | aclr_evt;
   end

   // bus slave: one write and one read in flight
   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take = s_axi_wvalid & s_axi_wready;
   wire ar_take = s_axi_arvalid & s_axi_arready;
   wire do_write = aw_held_q & w_held_q & ~bvalid_q;
   wire wr_ok = addr_known(awaddr_q);
   wire rd_ok = addr_known(s_axi_araddr);
   wire status_rd = ar_take & (s_axi_araddr == STATUS_OFS);

   assign s_axi_awready = ~aw_held_q & ~bvalid_q;
   assign s_axi_wready = ~w_held_q & ~bvalid_q;
   assign s_axi_arready = ~rvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rdata = rdata_q;

   logic [AXI_DW-1:0] rd_mux;
   always_comb begin
      rd_mux = '0;
      unique case (s_axi_araddr)
         CTRL_OFS: rd_mux[7:0] = ctrl_q;
         STATUS_OFS: rd_mux[ST_W-1:0] = status_q;
         MASK_OFS: rd_mux[ST_W-1:0] = mask_q;
         COUNT_OFS: begin
            rd_mux[W-1:0] = cif.count;
            rd_mux[COUNT_TERM_BIT] = cif.terminal_n;
            rd_mux[COUNT_DIR_BIT] = filt_q[PIN_DIR];
         end
         default: rd_mux = '0;
      endcase
   end

   // read clears, but an event in the same cycle survives
   assign status_d = (status_q & ~{ST_W{status_rd}}) | events;

   // address and data may come in either order; each waits here for the other
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         awaddr_q <= '0;
      end else if (aw_take) begin
         aw_held_q <= 1'b1;
         awaddr_q <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_q <= 1'b0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else if (w_take) begin
         w_held_q <= 1'b1;
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end else if (do_write) begin
         w_held_q <= 1'b0;
      end
   end

   // the answer is raised only once both halves are held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else if (do_write) begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // all writable fields sit in byte lane 0, so only strobe 0 matters
   wire wr_lane0 = do_write & wstrb_q[0];
   // one strobe per writable register; status and count ignore writes
   wire wr_ctrl = wr_lane0 & (awaddr_q == CTRL_OFS);
   wire wr_mask = wr_lane0 & (awaddr_q == MASK_OFS);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= CTRL_RST;
         mask_q <= MASK_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= wdata_q[7:0];
         end
         if (wr_mask) begin
            mask_q <= wdata_q[ST_W-1:0];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_q <= STATUS_RST;
      end else begin
         status_q <= status_d;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rresp_q <= RESP_OKAY;
         rdata_q <= '0;
      end else begin
         if (ar_take) begin
            rvalid_q <= 1'b1;
            rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            rdata_q <= rd_mux;
         end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // level output: stays high until a status read or a mask write drops it
   assign irq = |(status_q & mask_q);
endmodule

// ---- testbench/counter_properties.sv ----
// port-level assertions for the up/down counter
`timescale 1ns/100ps
module counter_properties
   import counter_pkg::*;
#(
   parameter int W = CNT_W
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic count_clock,
   input wire logic count_up,
   input wire logic parallel_load_n,
   input wire logic async_clear_n,
   input wire logic sync_clear_n,
   input wire logic count_enable_par_n,
   input wire logic count_enable_chain_n,
   input wire logic chip_select_n,
   input wire logic output_enable_n,
   input wire logic [W-1:0] io_out,
   input wire logic [W-1:0] io_oe,
   input wire logic terminal_count_n
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   property p_aclr;
      !async_clear_n |-> io_out == '0;
   endproperty
   a_aclr: assert property (p_aclr) else $error("count not cleared");
   // holds longer than the pin synchroniser needs
   property p_oe_off;
      output_enable_n [*6] |-> io_oe == '0;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("pins driven");
   property p_drive;
      (!chip_select_n && !output_enable_n && parallel_load_n) [*6] |-> io_oe == '1;
   endproperty
   a_drive: assert property (p_drive) else $error("pins not driven");
   property p_load_off;
      !parallel_load_n [*6] |-> io_oe == '0;
   endproperty
   a_load_off: assert property (p_load_off) else $error("pins driven in load");
   property p_tc_up;
      (!count_enable_chain_n && count_up) [*6] |-> terminal_count_n == (io_out != '1);
   endproperty
   a_tc_up: assert property (p_tc_up) else $error("end flag wrong going up");
   property p_tc_dn;
      (!count_enable_chain_n && !count_up) [*6] |-> terminal_count_n == (io_out != '0);
   endproperty
   a_tc_dn: assert property (p_tc_dn) else $error("end flag wrong going down");
   property p_tc_gate;
      count_enable_chain_n [*6] |-> terminal_count_n;
   endproperty
   a_tc_gate: assert property (p_tc_gate) else $error("end flag not gated");
   property p_hold;
      (count_enable_par_n && parallel_load_n && sync_clear_n && async_clear_n) [*8]
         |=> !async_clear_n || $stable(io_out);
   endproperty
   a_hold: assert property (p_hold) else $error("count moved while idle");
   property p_sclr;
      !sync_clear_n [*6] ##1 (!sync_clear_n && $rose(count_clock)) ##1 !sync_clear_n [*6]
         |-> io_out == '0;
   endproperty
   a_sclr: assert property (p_sclr) else $error("sync clear missed");
endmodule

bind up_down_binary_counter_8bit counter_properties #(.W(W)) props (.aclk(aclk),
   .aresetn(aresetn), .count_clock(count_clock), .count_up(count_up),
   .parallel_load_n(parallel_load_n), .async_clear_n(async_clear_n),
   .sync_clear_n(sync_clear_n), .count_enable_par_n(count_enable_par_n),
   .count_enable_chain_n(count_enable_chain_n), .chip_select_n(chip_select_n),
   .output_enable_n(output_enable_n), .io_out(io_out), .io_oe(io_oe),
   .terminal_count_n(terminal_count_n));

// ---- testbench/pin_partner.sv ----
// pin-side partner model for the shared i/o lines
`timescale 1ns/100ps
module pin_partner (
   input wire logic aclk,
   input wire logic drive_en,
   input wire logic [7:0] drive_val,
   input wire logic [7:0] io_out,
   input wire logic [7:0] io_oe,
   output logic [7:0] io_in
);
   logic [7:0] junk_q = 8'h00;
   // floating lines wander so a stale value is never trusted
   always_ff @(posedge aclk) begin
      junk_q <= ~junk_q;
   end
   // terminal count is never used here as a clock or reset
   assign io_in = (io_oe & io_out) | (~io_oe & (drive_en ? drive_val : junk_q));
endmodule

// ---- testbench/tb.sv ----
// self-checking bench for the up/down counter
`timescale 1ns/100ps
module tb;
   import counter_pkg::*;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [7:0] awaddr = '0, araddr = '0, drv_val = '0, io_in, io_out, io_oe, ex;
   logic [31:0] wdata = '0, rdata, q, v;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic cclk = 1'h0, up = 1'h1, ld_n = 1'h1, ac_n = 1'h1, sc_n = 1'h1, cep_n = 1'h1;
   logic cet_n = 1'h1, cs_n = 1'h1, oe_n = 1'h1, drv_en = 1'h0, u, p, t;
   logic awready, wready, bvalid, arready, rvalid, tc_n, irq;
   logic [1:0] bresp, rresp, rs;
   int errors = 0, cmp_count = 0, seed = 32'heeda, i;

   up_down_binary_counter_8bit dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .count_clock(cclk),
      .count_up(up), .parallel_load_n(ld_n), .async_clear_n(ac_n), .sync_clear_n(sc_n),
      .count_enable_par_n(cep_n), .count_enable_chain_n(cet_n), .chip_select_n(cs_n),
      .output_enable_n(oe_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
      .terminal_count_n(tc_n), .irq(irq));
   pin_partner far (.aclk(aclk), .drive_en(drv_en), .drive_val(drv_val), .io_out(io_out),
      .io_oe(io_oe), .io_in(io_in));

   initial begin
      forever #12.5 aclk = ~aclk;
   end

   function automatic logic [7:0] nxt(input logic [7:0] c, input logic d, input logic en);
      return en ? (d ? c + 8'h01 : c - 8'h01) : c;
   endfunction
   function automatic logic tcx(input logic [7:0] c, input logic d, input logic tn);
      return !(!tn && (d ? c == 8'hff : c == 8'h00));
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("Error %0t got %h want %h", $time, got, exp);
      end
   endtask

   task automatic end_sim();
      if (errors == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // one write or one read, each channel held until its own ready
   task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
      logic pa, pw, dn;
      @(posedge aclk);
      pa = 1'h1;
      pw = we;
      dn = 1'h0;
      awaddr <= a;
      araddr <= a;
      wdata <= d;
      awvalid <= we;
      wvalid <= we;
      arvalid <= !we;
      bready <= we;
      rready <= !we;
      while (!dn) begin
         @(posedge aclk);
         if (pa && (we ? awready : arready)) begin
            pa = 1'h0;
            awvalid <= 1'h0;
            arvalid <= 1'h0;
         end
         if (pw && wready) begin
            pw = 1'h0;
            wvalid <= 1'h0;
         end
         if (we ? bvalid : rvalid) begin
            dn = 1'h1;
            q = rdata;
            rs = we ? bresp : rresp;
            bready <= 1'h0;
            rready <= 1'h0;
         end
      end
   endtask

   // pins held well past the synchroniser either side of the rise
   task automatic step();
      repeat (6) @(posedge aclk);
      cclk <= 1'h1;
      repeat (6) @(posedge aclk);
      cclk <= 1'h0;
      repeat (6) @(posedge aclk);
   endtask

   task automatic ld(input logic [7:0] val, input logic cs);
      @(posedge aclk);
      cs_n <= cs;
      ld_n <= 1'h0;
      drv_en <= 1'h1;
      drv_val <= val;
      step();
      ld_n <= 1'h1;
      cs_n <= 1'h1;
      drv_en <= 1'h0;
      if (!cs)
         ex = val;
   endtask

   initial begin
      repeat (20000) @(posedge aclk);
      errors++;
      end_sim();
   end

   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'h1;
      bus(1'h0, CTRL_OFS, '0);
      chk(q, {24'h0, CTRL_RST});
      bus(1'h0, MASK_OFS, '0);
      chk(q, {29'h0, MASK_RST});
      bus(1'h0, 8'h10, '0);
      chk(q, 32'h0);
      chk(rs, RESP_SLVERR);
      bus(1'h1, 8'h10, 32'hff);
      chk(rs, RESP_SLVERR);
      ld(8'hfe, 1'h0);
      chk(io_out, ex);
      ld(8'h11, 1'h1);
      chk(io_out, ex);
      for (i = 0; i < 28; i++) begin
         v = $random(seed);
         u = i < 4 ? i < 2 : v[0];
         p = i < 4 ? i == 2 : v[1] & v[2];
         t = i < 4 ? 1'h0 : v[3] & v[4];
         up <= u;
         cep_n <= p;
         cet_n <= t;
         step();
         ex = nxt(ex, u, !p && !t);
         chk(io_out, ex);
         chk(tc_n, tcx(ex, u, t));
      end
      bus(1'h0, COUNT_OFS, '0);
      chk(q, {22'h0, u, tcx(ex, u, t), ex});
      // run bit off: a full step with both enables low must leave the count alone
      bus(1'h1, CTRL_OFS, 32'h0);
      bus(1'h0, CTRL_OFS, '0);
      chk(q, 32'h0);
      cep_n <= 1'h0;
      cet_n <= 1'h0;
      step();
      chk(io_out, ex);
      bus(1'h1, CTRL_OFS, {24'h0, CTRL_RST});
      cet_n <= 1'h1;
      sc_n <= 1'h0;
      ld(8'h5a, 1'h0);
      sc_n <= 1'h1;
      chk(io_out, 8'h00);
      ld(8'h33, 1'h0);
      bus(1'h0, STATUS_OFS, '0);
      chk(q, (32'h1 << ST_TERM_BIT) | (32'h1 << ST_LOAD_BIT) | (32'h1 << ST_CLEAR_BIT));
      ac_n <= 1'h0;
      #2;
      chk(io_out, 8'h00);
      repeat (8) @(posedge aclk);
      ac_n <= 1'h1;
      repeat (8) @(posedge aclk);
      chk(irq, 1'h0);
      bus(1'h1, MASK_OFS, 32'h1 << ST_CLEAR_BIT);
      chk(irq, 1'h1);
      bus(1'h0, STATUS_OFS, '0);
      chk(q, 32'h1 << ST_CLEAR_BIT);
      chk(irq, 1'h0);
      cs_n <= 1'h0;
      oe_n <= 1'h0;
      repeat (6) @(posedge aclk);
      chk(io_oe, 8'hff);
      chk(io_in, io_out);
      oe_n <= 1'h1;
      repeat (6) @(posedge aclk);
      chk(io_oe, 8'h00);
      end_sim();
   end
endmodule
